// ---- rtl/pfd_pkg.sv ----
package pfd_pkg;

    // Phase order of one waveform timer cycle, Gray coded along the usual path
    typedef enum logic [1:0] {
        PH_DTA = 2'b00,
        PH_OTA = 2'b01,
        PH_DTB = 2'b11,
        PH_OTB = 2'b10
    } pfd_phase_t;

    // Fault input behaviour codes
    localparam logic [3:0] FIB_NONE = 4'h0;
    localparam logic [3:0] FIB_JUMP_WAIT = 4'h1;
    localparam logic [3:0] FIB_REPEAT = 4'h3;
    localparam logic [3:0] FIB_ALL_OFF = 4'h4;
    localparam logic [3:0] FIB_ALL_WAIT = 4'h6;
    localparam logic [3:0] FIB_ALL_SW = 4'h7;
    localparam logic [3:0] FIB_EDGE_JUMP = 4'h8;
    localparam logic [3:0] FIB_EDGE_BLOCK = 4'h9;
    localparam logic [3:0] FIB_LEVEL_BLOCK = 4'ha;

    // Waveform modes
    localparam logic [1:0] WM_ONE = 2'h0;
    localparam logic [1:0] WM_TWO = 2'h1;
    localparam logic [1:0] WM_FOUR = 2'h2;
    localparam logic [1:0] WM_DUAL = 2'h3;

    // Dither placement codes
    localparam logic [1:0] DP_OTB = 2'h0;
    localparam logic [1:0] DP_OTAB = 2'h1;
    localparam logic [1:0] DP_DTB = 2'h2;
    localparam logic [1:0] DP_DTAB = 2'h3;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BEHAVIOUR = 8'h04;
    localparam logic [7:0] OFS_EV_FIRST = 8'h08;
    localparam logic [7:0] OFS_EV_SECOND = 8'h0c;
    localparam logic [7:0] OFS_DEAD_LEN = 8'h10;
    localparam logic [7:0] OFS_ON_LEN = 8'h14;
    localparam logic [7:0] OFS_DITHER = 8'h18;
    localparam logic [7:0] OFS_CMD = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_FLAGS = 8'h24;
    localparam logic [7:0] OFS_IEN = 8'h28;
    localparam logic [7:0] OFS_CAP1_LO = 8'h2c;
    localparam logic [7:0] OFS_CAP1_HI = 8'h30;
    localparam logic [7:0] OFS_CAP2_LO = 8'h34;
    localparam logic [7:0] OFS_CAP2_HI = 8'h38;

    // Field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_WM = 1;
    localparam int CTRL_DP = 3;
    localparam int BEH_B = 4;
    localparam int EV_ACTION = 0;
    localparam int EV_FALL = 1;
    localparam int CMD_RESTART = 0;
    localparam int CMD_CAP1 = 1;
    localparam int CMD_CAP2 = 2;
    localparam int ST_DONE = 0;
    localparam int ST_HALT = 1;
    localparam int ST_WAIT = 2;
    localparam int ST_PHASE = 3;

    // Reset values
    localparam logic [11:0] RST_DEAD_LEN = 12'h004;
    localparam logic [11:0] RST_ON_LEN = 12'h010;

endpackage

// ---- rtl/pfd_event_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for the event inputs
module pfd_event_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/pfd_fault_dither_capture.sv ----
// What this block does
// - Mode 8: rising edge while own output on stops it, jumps opposite dead-time.
// - Mode 8: edge A in on-time A goes dead-time B; B goes dead-time A.
// - Mode 9: rising edge in own on-time blocks output rest of on-time.
// - Mode 10: output off while input high, and to end of that on-time.
// - Mode 1: fault ends own on-time, counter waits, resumes other dead-time.
// - Mode 3: own output off during fault; other compare cycle repeats while fault active.
// - Mode 6: either input ends both on-times, waits, resumes other dead-time.
// - Mode 7: either input stops both outputs, counter halts until restart.
// - Mode 9 only suppresses the pulse; phase sequence keeps running.
// - Fraction accumulates each cycle; overflow lengthens each placed phase by one clock.
// - Placement picks on-time B, on-times, dead-time B or dead-times.
// - Dithering does nothing in dual slope mode.
// - Cycle growth per overflow follows the waveform mode and placement.
// - Lengthening that adds no period shortens the next phase by one.
// - Two capture units, triggered by own event input or software strobe.
// - Event capture only when the input's capture action bit is set.
// - Each capture sets a done flag; per-unit enable raises interrupt.
// - Restart always begins at dead-time A; active fault stops it again.
// - Software capture strobe; value valid once command done reads 1.
`timescale 1ns/1ps
`default_nettype none

module pfd_fault_dither_capture #(
    parameter int CNT_W = 12,
    parameter int FRAC_W = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic event_in_a,
    input wire logic event_in_b,
    output logic wave_output_a,
    output logic wave_output_b,
    output logic capture_irq
);

    typedef struct packed {
        pfd_pkg::pfd_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic ext;
        logic shr;
        logic [FRAC_W-1:0] acc;
        logic dith_pend;
        logic halt;
        logic hold;
        pfd_pkg::pfd_phase_t resume;
        logic [1:0] blk;
        logic [1:0] ev_q;
        logic enable;
        logic [1:0] wmode;
        logic [1:0] dsel;
        logic [3:0] mode_a;
        logic [3:0] mode_b;
        logic [1:0] act;
        logic [1:0] fall;
        logic [CNT_W-1:0] dt_len;
        logic [CNT_W-1:0] ot_len;
        logic [FRAC_W-1:0] frac;
        logic [2:0] cmd_pend;
        logic cmd_done;
        logic [1:0] flags;
        logic [1:0] ien;
        logic [15:0] cap_a;
        logic [15:0] cap_b;
        logic [7:0] hi_a;
        logic [7:0] hi_b;
        logic ack;
        logic [31:0] dat;
        logic out_a;
        logic out_b;
        logic irq;
    } pfd_state_t;

    pfd_state_t s;
    pfd_state_t n;
    logic [1:0] ev;
    logic [1:0] rise;
    logic [1:0] drop;
    logic [1:0] own_dt;
    logic [1:0] own_ot;
    logic [1:0] off;
    logic [1:0] cap_trig;
    logic [3:0] mode [2];
    logic f4;
    logic f6;
    logic f7;
    logic wait1;
    logic go;
    logic cyc_end;
    logic carry;
    logic last;
    logic req;
    logic [FRAC_W-1:0] acc_sum;
    logic [CNT_W:0] len_eff;
    logic [31:0] wdat;
    pfd_pkg::pfd_phase_t tgt;
    pfd_pkg::pfd_phase_t res1;

    pfd_event_sync #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({event_in_b, event_in_a}),
        .sync_out(ev)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (val & m);
    endfunction

    // True when lengthening this phase also lengthens the whole cycle
    function automatic logic counts(input pfd_pkg::pfd_phase_t ph, input logic [1:0] wm);
        case (wm)
            pfd_pkg::WM_FOUR: counts = 1'b1;
            pfd_pkg::WM_TWO: counts = (ph == pfd_pkg::PH_OTA) || (ph == pfd_pkg::PH_OTB);
            default: counts = (ph == pfd_pkg::PH_OTB);
        endcase
    endfunction

    function automatic logic placed(input pfd_pkg::pfd_phase_t ph, input logic [1:0] ds);
        case (ds)
            pfd_pkg::DP_OTB: placed = (ph == pfd_pkg::PH_OTB);
            pfd_pkg::DP_OTAB: placed = (ph == pfd_pkg::PH_OTA) || (ph == pfd_pkg::PH_OTB);
            pfd_pkg::DP_DTB: placed = (ph == pfd_pkg::PH_DTB);
            default: placed = (ph == pfd_pkg::PH_DTA) || (ph == pfd_pkg::PH_DTB);
        endcase
    endfunction

    function automatic pfd_pkg::pfd_phase_t next_phase(input pfd_pkg::pfd_phase_t ph);
        case (ph)
            pfd_pkg::PH_DTA: next_phase = pfd_pkg::PH_OTA;
            pfd_pkg::PH_OTA: next_phase = pfd_pkg::PH_DTB;
            pfd_pkg::PH_DTB: next_phase = pfd_pkg::PH_OTB;
            default: next_phase = pfd_pkg::PH_DTA;
        endcase
    endfunction

    always_comb begin
        n = s;
        n.ack = 1'b0;
        n.dat = 32'h0000_0000;
        n.ev_q = ev;
        rise = ev & ~s.ev_q;
        drop = ~ev & s.ev_q;
        mode[0] = s.mode_a;
        mode[1] = s.mode_b;
        own_dt = {s.phase == pfd_pkg::PH_DTB, s.phase == pfd_pkg::PH_DTA};
        own_ot = {s.phase == pfd_pkg::PH_OTB, s.phase == pfd_pkg::PH_OTA};
        f4 = 1'b0;
        f6 = 1'b0;
        f7 = 1'b0;
        wait1 = 1'b0;
        res1 = pfd_pkg::PH_DTA;
        off = 2'b00;
        go = 1'b0;
        tgt = s.phase;
        cap_trig = 2'b00;
        wdat = 32'h0000_0000;
        req = wb_cyc_i && wb_stb_i && !s.ack;

        // Undefined codes match none of the cases below and do nothing
        for (int i = 0; i < 2; i++) begin
            f4 = f4 || (mode[i] == pfd_pkg::FIB_ALL_OFF && ev[i]);
            f6 = f6 || (mode[i] == pfd_pkg::FIB_ALL_WAIT && ev[i]);
            f7 = f7 || (mode[i] == pfd_pkg::FIB_ALL_SW && ev[i]);
            if (mode[i] == pfd_pkg::FIB_JUMP_WAIT && ev[i] && (own_dt[i] || own_ot[i])) begin
                wait1 = 1'b1;
                res1 = (i == 0) ? pfd_pkg::PH_DTB : pfd_pkg::PH_DTA;
            end
            if ((mode[i] == pfd_pkg::FIB_JUMP_WAIT || mode[i] == pfd_pkg::FIB_REPEAT ||
                 mode[i] == pfd_pkg::FIB_LEVEL_BLOCK) && ev[i]) begin
                off[i] = 1'b1;
            end
        end

        // Register bus
        if (req) begin
            n.ack = 1'b1;
            n.dat = 32'h0000_0000;
            if (wb_we_i) begin
                case (wb_adr_i)
                    pfd_pkg::OFS_CTRL: begin
                        wdat = merge({27'h0, s.dsel, s.wmode, s.enable}, wb_dat_i, wb_sel_i);
                        n.enable = wdat[pfd_pkg::CTRL_EN];
                        n.wmode = wdat[pfd_pkg::CTRL_WM +: 2];
                        n.dsel = wdat[pfd_pkg::CTRL_DP +: 2];
                    end
                    pfd_pkg::OFS_BEHAVIOUR: begin
                        wdat = merge({24'h0, s.mode_b, s.mode_a}, wb_dat_i, wb_sel_i);
                        n.mode_a = wdat[3:0];
                        n.mode_b = wdat[pfd_pkg::BEH_B +: 4];
                    end
                    pfd_pkg::OFS_EV_FIRST: begin
                        wdat = merge({30'h0, s.fall[0], s.act[0]}, wb_dat_i, wb_sel_i);
                        n.act[0] = wdat[pfd_pkg::EV_ACTION];
                        n.fall[0] = wdat[pfd_pkg::EV_FALL];
                    end
                    pfd_pkg::OFS_EV_SECOND: begin
                        wdat = merge({30'h0, s.fall[1], s.act[1]}, wb_dat_i, wb_sel_i);
                        n.act[1] = wdat[pfd_pkg::EV_ACTION];
                        n.fall[1] = wdat[pfd_pkg::EV_FALL];
                    end
                    pfd_pkg::OFS_DEAD_LEN: begin
                        wdat = merge(32'(s.dt_len), wb_dat_i, wb_sel_i);
                        n.dt_len = wdat[CNT_W-1:0];
                    end
                    pfd_pkg::OFS_ON_LEN: begin
                        wdat = merge(32'(s.ot_len), wb_dat_i, wb_sel_i);
                        n.ot_len = wdat[CNT_W-1:0];
                    end
                    pfd_pkg::OFS_DITHER: begin
                        wdat = merge(32'(s.frac), wb_dat_i, wb_sel_i);
                        n.frac = wdat[FRAC_W-1:0];
                    end
                    pfd_pkg::OFS_CMD: begin
                        if (wb_sel_i[0] && (|wb_dat_i[2:0])) begin
                            n.cmd_pend = wb_dat_i[2:0];
                            n.cmd_done = 1'b0;
                        end
                    end
                    pfd_pkg::OFS_FLAGS: begin
                        if (wb_sel_i[0]) begin
                            n.flags = s.flags & ~wb_dat_i[1:0];
                        end
                    end
                    pfd_pkg::OFS_IEN: begin
                        wdat = merge({30'h0, s.ien}, wb_dat_i, wb_sel_i);
                        n.ien = wdat[1:0];
                    end
                    default: n.dat = 32'h0000_0000;
                endcase
            end else begin
                case (wb_adr_i)
                    pfd_pkg::OFS_CTRL: n.dat = {27'h0, s.dsel, s.wmode, s.enable};
                    pfd_pkg::OFS_BEHAVIOUR: n.dat = {24'h0, s.mode_b, s.mode_a};
                    pfd_pkg::OFS_EV_FIRST: n.dat = {30'h0, s.fall[0], s.act[0]};
                    pfd_pkg::OFS_EV_SECOND: n.dat = {30'h0, s.fall[1], s.act[1]};
                    pfd_pkg::OFS_DEAD_LEN: n.dat = 32'(s.dt_len);
                    pfd_pkg::OFS_ON_LEN: n.dat = 32'(s.ot_len);
                    pfd_pkg::OFS_DITHER: n.dat = 32'(s.frac);
                    pfd_pkg::OFS_STATUS: begin
                        n.dat[pfd_pkg::ST_DONE] = s.cmd_done;
                        n.dat[pfd_pkg::ST_HALT] = s.halt;
                        n.dat[pfd_pkg::ST_WAIT] = s.hold;
                        n.dat[pfd_pkg::ST_PHASE +: 2] = s.phase;
                    end
                    pfd_pkg::OFS_FLAGS: n.dat = {30'h0, s.flags};
                    pfd_pkg::OFS_IEN: n.dat = {30'h0, s.ien};
                    pfd_pkg::OFS_CAP1_LO: begin
                        n.dat = {24'h0, s.cap_a[7:0]};
                        n.hi_a = s.cap_a[15:8];
                    end
                    pfd_pkg::OFS_CAP1_HI: n.dat = {24'h0, s.hi_a};
                    pfd_pkg::OFS_CAP2_LO: begin
                        n.dat = {24'h0, s.cap_b[7:0]};
                        n.hi_b = s.cap_b[15:8];
                    end
                    pfd_pkg::OFS_CAP2_HI: n.dat = {24'h0, s.hi_b};
                    default: n.dat = 32'h0000_0000;
                endcase
            end
        end

        // Phase length including dither extension and compensation
        len_eff = {1'b0, (own_ot != 2'b00) ? s.ot_len : s.dt_len}
                  + (CNT_W+1)'(s.ext) - (CNT_W+1)'(s.shr);
        if (len_eff == '0) begin
            len_eff = (CNT_W+1)'(1);
        end
        last = ({1'b0, s.cnt} >= len_eff - (CNT_W+1)'(1));

        // Counter sequencing
        if (!s.enable) begin
            n.phase = pfd_pkg::PH_DTA;
            n.cnt = '0;
            n.hold = 1'b0;
            n.halt = 1'b0;
        end else if (s.cmd_pend[pfd_pkg::CMD_RESTART]) begin
            n.halt = 1'b0;
            n.hold = 1'b0;
            go = 1'b1;
            tgt = pfd_pkg::PH_DTA;
        end else if (s.halt || f7) begin
            n.halt = 1'b1;
        end else if (wait1) begin
            n.hold = 1'b1;
            n.resume = res1;
        end else if (f6 && (own_ot != 2'b00)) begin
            go = 1'b1;
            tgt = next_phase(s.phase);
        end else if (f6 && last) begin
            n.hold = 1'b1;
            n.resume = (s.phase == pfd_pkg::PH_DTA) ? pfd_pkg::PH_DTB : pfd_pkg::PH_DTA;
        end else if (s.hold) begin
            n.hold = 1'b0;
            go = 1'b1;
            tgt = s.resume;
        end else if (s.mode_a == pfd_pkg::FIB_EDGE_JUMP && rise[0] && own_ot[0]) begin
            go = 1'b1;
            tgt = pfd_pkg::PH_DTB;
        end else if (s.mode_b == pfd_pkg::FIB_EDGE_JUMP && rise[1] && own_ot[1]) begin
            go = 1'b1;
            tgt = pfd_pkg::PH_DTA;
        end else if (last) begin
            go = 1'b1;
            tgt = next_phase(s.phase);
            if (s.phase == pfd_pkg::PH_OTB && s.mode_a == pfd_pkg::FIB_REPEAT && ev[0]) begin
                tgt = pfd_pkg::PH_DTB;
            end
            if (s.phase == pfd_pkg::PH_OTA && s.mode_b == pfd_pkg::FIB_REPEAT && ev[1]) begin
                tgt = pfd_pkg::PH_DTA;
            end
        end else begin
            n.cnt = s.cnt + CNT_W'(1);
        end

        // Phase entry and dither accumulation
        cyc_end = go && (tgt == pfd_pkg::PH_DTA);
        {carry, acc_sum} = {1'b0, s.acc} + {1'b0, s.frac};
        if (go) begin
            n.phase = tgt;
            n.cnt = '0;
            if (cyc_end) begin
                n.acc = acc_sum;
                n.dith_pend = carry && (s.wmode != pfd_pkg::WM_DUAL);
            end
            n.ext = n.dith_pend && placed(tgt, s.dsel) && (s.wmode != pfd_pkg::WM_DUAL);
            n.shr = s.ext && !counts(s.phase, s.wmode);
        end

        // Edge and level blocking of the own on-time, cleared when it ends
        for (int i = 0; i < 2; i++) begin
            if (n.phase != ((i == 0) ? pfd_pkg::PH_OTA : pfd_pkg::PH_OTB)) begin
                n.blk[i] = 1'b0;
            end else if (own_ot[i] && ((mode[i] == pfd_pkg::FIB_EDGE_BLOCK && rise[i]) ||
                                       (mode[i] == pfd_pkg::FIB_LEVEL_BLOCK && ev[i]))) begin
                n.blk[i] = 1'b1;
            end
        end

        n.out_a = n.enable && (n.phase == pfd_pkg::PH_OTA) && !n.blk[0] && !off[0] &&
                  !f4 && !f6 && !n.halt && !n.hold;
        n.out_b = n.enable && (n.phase == pfd_pkg::PH_OTB) && !n.blk[1] && !off[1] &&
                  !f4 && !f6 && !n.halt && !n.hold;

        // Capture units
        for (int i = 0; i < 2; i++) begin
            cap_trig[i] = (s.act[i] && (s.fall[i] ? drop[i] : rise[i])) ||
                          s.cmd_pend[pfd_pkg::CMD_CAP1 + i];
        end
        if (cap_trig[0]) begin
            n.cap_a = 16'(s.cnt);
        end
        if (cap_trig[1]) begin
            n.cap_b = 16'(s.cnt);
        end
        n.flags = n.flags | cap_trig;
        if (s.cmd_pend != 3'b000) begin
            n.cmd_pend = 3'b000;
            n.cmd_done = 1'b1;
        end
        n.irq = |(n.flags & n.ien);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.dt_len <= CNT_W'(pfd_pkg::RST_DEAD_LEN);
            s.ot_len <= CNT_W'(pfd_pkg::RST_ON_LEN);
            s.cmd_done <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign wave_output_a = s.out_a;
    assign wave_output_b = s.out_b;
    assign capture_irq = s.irq;

endmodule

`default_nettype wire

// ---- testbench/pfd_event_net.sv ----
`timescale 1ns/1ps
`default_nettype none

// Event routing channel: one register stage from source to timer input
module pfd_event_net (
    input wire logic clk_sys,
    input wire logic src_a,
    input wire logic src_b,
    input wire logic share,
    output logic event_in_a,
    output logic event_in_b
);
    initial begin
        event_in_a = 1'b0;
        event_in_b = 1'b0;
    end
    always @(posedge clk_sys) begin
        event_in_a <= src_a;
        event_in_b <= share ? src_a : src_b;
    end
endmodule

`default_nettype wire

// ---- testbench/pfd_fdc_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module pfd_fdc_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic event_in_a,
    input wire logic event_in_b,
    input wire logic wave_output_a,
    input wire logic wave_output_b,
    input wire logic capture_irq
);
    logic [3:0] beh_a;
    logic [1:0] ien;
    logic [4:0] hist_a;
    wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    // Input A seen high long enough to pass the synchroniser
    wire logic held = &hist_a;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            beh_a <= 4'h0;
            ien <= 2'h0;
            hist_a <= 5'h00;
        end else begin
            hist_a <= {hist_a[3:0], event_in_a};
            if (wr && wb_adr_i == pfd_pkg::OFS_BEHAVIOUR) begin
                beh_a <= wb_dat_i[3:0];
            end
            if (wr && wb_adr_i == pfd_pkg::OFS_IEN) begin
                ien <= wb_dat_i[1:0];
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_EXCL: assert property (!(wave_output_a && wave_output_b))
        else $error("both outputs on");
    AST_M1_A: assert property (beh_a == pfd_pkg::FIB_JUMP_WAIT && held |-> !wave_output_a)
        else $error("output a on during fault");
    AST_M6_A: assert property (beh_a == pfd_pkg::FIB_ALL_WAIT && held |->
        !wave_output_a && !wave_output_b) else $error("output on during fault");
    AST_M7_A: assert property (beh_a == pfd_pkg::FIB_ALL_SW && held |->
        !(wave_output_a || wave_output_b)) else $error("output on during halt");
    AST_M10_A: assert property (beh_a == pfd_pkg::FIB_LEVEL_BLOCK && held |->
        !wave_output_a) else $error("output a on while input high");
    AST_IRQ_OFF: assert property (ien == 2'h0 |-> !capture_irq)
        else $error("interrupt while disabled");
    CV_LEVEL: cover property (beh_a == pfd_pkg::FIB_LEVEL_BLOCK && held);
    CV_IRQ: cover property (capture_irq);
    CV_HALT: cover property (beh_a == pfd_pkg::FIB_ALL_SW && $fell(event_in_a));
endmodule

bind pfd_fault_dither_capture pfd_fdc_sva pfd_fdc_sva_inst (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_in_a(event_in_a), .event_in_b(event_in_b), .wave_output_a(wave_output_a),
    .wave_output_b(wave_output_b), .capture_irq(capture_irq));

`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr, rd;
    logic ack, wa, wb, irq, ev_a, ev_b;
    logic src_a = 1'b0;
    logic share = 1'b0;
    int bad_count = 0;
    int n_tests = 0;
    always #4 clk_sys = ~clk_sys;
    pfd_event_net pfd_event_net_inst (.clk_sys(clk_sys), .src_a(src_a), .src_b(1'b0),
        .share(share), .event_in_a(ev_a), .event_in_b(ev_b));
    pfd_fault_dither_capture pfd_fault_dither_capture_inst (.clk_sys(clk_sys), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .event_in_a(ev_a), .event_in_b(ev_b),
        .wave_output_a(wa), .wave_output_b(wb), .capture_irq(irq));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do begin
            @(posedge clk_sys);
            i++;
        end while (ack !== 1'b1 && i < 50);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 50) begin
            bad_count++;
            print_verdict();
        end
    endtask
    // Counts edges until the chosen output is sampled at lvl
    task automatic wait_out(input logic b, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((b ? wb : wa) !== lvl && n < 300);
        if (n >= 300) begin
            bad_count++;
            print_verdict();
        end
    endtask
    task automatic t_dither();
        // {waveform mode, placement, cycles in two periods}
        logic [11:0] tab [7] = '{12'h250, 12'h151, 12'h552, 12'h750, 12'hb52, 12'ha51, 12'hd50};
        int n;
        int t;
        bus(1'b1, pfd_pkg::OFS_DITHER, 32'h8);
        foreach (tab[k]) begin
            bus(1'b1, pfd_pkg::OFS_CTRL, {27'h0, tab[k][9:8], tab[k][11:10], 1'b1});
            wait_out(1'b0, 1'b1, n);
            wait_out(1'b0, 1'b0, n);
            wait_out(1'b0, 1'b1, n);
            t = 0;
            for (int j = 0; j < 4; j++) begin
                wait_out(1'b0, j[0], n);
                t += n;
            end
            check(t, 32'(tab[k][7:0]));
        end
    endtask
    task automatic t_swcap();
        logic [15:0] v;
        int i;
        bus(1'b1, pfd_pkg::OFS_IEN, 32'h1);
        bus(1'b1, pfd_pkg::OFS_CMD, 32'h2);
        i = 0;
        do begin
            bus(1'b0, pfd_pkg::OFS_STATUS, 32'h0);
            i++;
        end while (rd[0] !== 1'b1 && i < 10);
        check(rd[0], 1'b1);
        bus(1'b0, pfd_pkg::OFS_FLAGS, 32'h0);
        check(rd[1:0], 2'h1);
        check(irq, 1'b1);
        // Phases are at most 16 clocks long, so the high byte is zero
        v = 16'h0000;
        for (i = 0; i < 2; i++) begin
            bus(1'b0, pfd_pkg::OFS_CAP1_LO, 32'h0);
            if (i == 0) v[7:0] = rd[7:0];
            check({rd[7:0] == v[7:0], v[7:0] <= 8'h10}, 2'h3);
            bus(1'b0, pfd_pkg::OFS_CAP1_HI, 32'h0);
            check(rd[7:0], v[15:8]);
        end
        bus(1'b1, pfd_pkg::OFS_FLAGS, 32'h1);
        bus(1'b0, pfd_pkg::OFS_FLAGS, 32'h0);
        check(rd[1:0], 2'h0);
        check(irq, 1'b0);
        bus(1'b1, pfd_pkg::OFS_IEN, 32'h0);
    endtask
    task automatic t_faults();
        logic [3:0] m [5] = '{4'h1, 4'h6, 4'h7, 4'ha, 4'hf};
        int c;
        bus(1'b1, pfd_pkg::OFS_DITHER, 32'h0);
        bus(1'b1, pfd_pkg::OFS_CTRL, 32'h5);
        foreach (m[k]) begin
            // Input B stays at no action, so the shared counter has one master
            bus(1'b1, pfd_pkg::OFS_BEHAVIOUR, 32'(m[k]));
            src_a <= 1'b1;
            repeat (8) @(posedge clk_sys);
            c = 0;
            repeat (50) begin
                @(posedge clk_sys);
                c += (wa !== 1'b0);
            end
            check(c == 0, m[k] != 4'hf);
            bus(1'b0, pfd_pkg::OFS_STATUS, 32'h0);
            check(rd[pfd_pkg::ST_HALT], m[k] == 4'h7);
            check(rd[pfd_pkg::ST_WAIT], m[k] == 4'h1 || m[k] == 4'h6);
            src_a <= 1'b0;
            repeat (8) @(posedge clk_sys);
            bus(1'b1, pfd_pkg::OFS_CMD, 32'h1);
            bus(1'b0, pfd_pkg::OFS_STATUS, 32'h0);
            check(rd[4:1], 4'h0);
        end
    endtask
    task automatic t_edge();
        logic [3:0] m [2] = '{pfd_pkg::FIB_EDGE_JUMP, pfd_pkg::FIB_EDGE_BLOCK};
        int n;
        foreach (m[k]) begin
            bus(1'b1, pfd_pkg::OFS_BEHAVIOUR, 32'(m[k]));
            wait_out(1'b0, 1'b0, n);
            wait_out(1'b0, 1'b1, n);
            src_a <= 1'b1;
            wait_out(1'b0, 1'b0, n);
            check(n < 12, 1'b1);
            wait_out(1'b1, 1'b1, n);
            check(n <= 7, m[k] == pfd_pkg::FIB_EDGE_JUMP);
            src_a <= 1'b0;
        end
        bus(1'b1, pfd_pkg::OFS_BEHAVIOUR, 32'h0);
    endtask
    task automatic t_evcap();
        share <= 1'b1;
        bus(1'b1, pfd_pkg::OFS_EV_FIRST, 32'h1);
        bus(1'b1, pfd_pkg::OFS_FLAGS, 32'h3);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, pfd_pkg::OFS_EV_SECOND, i ? 32'h3 : 32'h0);
            src_a <= 1'b1;
            repeat (10) @(posedge clk_sys);
            src_a <= 1'b0;
            repeat (10) @(posedge clk_sys);
            bus(1'b0, pfd_pkg::OFS_FLAGS, 32'h0);
            check(rd[1:0], i ? 2'h3 : 2'h1);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_dither();
        t_swcap();
        t_faults();
        t_edge();
        t_evcap();
        print_verdict();
    end
endmodule

`default_nettype wire
